/* File: rsh_switchover.sv */
/*
 * Reference switchover, holdover, receiver power-down, divider settings
 * and oscillator band calibration behind an AXI4-Lite register slave.
 * Assumes presence flags, select pin and band comparator are asynchronous
 * levels; analog parts act on the control outputs.
 */
// Operation
// - Both reference presence monitors steer automatic selection and holdover entry.
// - Manual selection by control register or by the select pin.
// - Auto mode switches to secondary when primary lost and secondary present.
// - Nonrevertive: stay on secondary; return only when secondary lost.
// - Revertive: with no nonrevertive switch recorded, return to primary as soon as it is seen again.
// - Nonrevertive switch record is cleared only by device reset.
// - No reference present: enter holdover, charge pump tristated.
// - Optionally drive tuning node to mid-supply in holdover.
// - Leave holdover when a reference appears; resync cleanup loop.
// - A control bit disables automatic holdover entry.
// - Multiplier loop stays on oscillator and locked during holdover.
// - Each reference divider programmable 1 to 1023.
// - Differential receiver off when not selected or loop powered down.
// - Single-ended buffer off on loop down, own bit, or differential select.
// - Oscillator to distribution divider is 3, 4 or 5.
// - Each output has divider 1 to 256 and coarse delay.
// - Optional doubler on multiplier loop reference input.
// - Oscillator tuning band chosen automatically by calibration.
`timescale 1ns/1ns
`default_nettype none
module rsh_switchover (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reference monitors and select pin
  input wire logic primary_reference_present,
  input wire logic secondary_reference_present,
  input wire logic ref_select_pin,
  // Band comparator from the oscillator
  input wire logic vco_band_too_high,
  // Switchover and charge pump control
  output logic use_secondary_reference,
  output logic holdover_active,
  output logic cleanup_loop_cp_tristate,
  output logic cleanup_loop_cp_midsupply,
  output logic cleanup_loop_resync,
  // Receiver power-down
  output logic diff_receiver_pd,
  output logic se_buffer_pd_primary,
  output logic se_buffer_pd_secondary,
  // Divider and multiplier loop settings
  output logic [rsh_pkg::REFDIV_W-1:0] primary_reference_div,
  output logic [rsh_pkg::REFDIV_W-1:0] secondary_reference_div,
  output logic [rsh_pkg::VDIV_W-1:0] vco_out_div,
  output rsh_pkg::rsh_out_cfg_t [rsh_pkg::NUM_OUT-1:0] out_cfg,
  output logic multiplier_loop_doubler_en,
  output logic [rsh_pkg::BAND_W-1:0] vco_band,
  output logic vco_cal_busy
);
  rsh_pkg::rsh_state_t s;
  rsh_pkg::rsh_state_t next_s;

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  // Read value of an address, bit 32 set when the address is mapped
  function automatic logic [32:0] reg_read(input rsh_pkg::rsh_state_t st,
                                           input logic [7:0] a);
    logic [32:0] r;
    logic [7:0] idx;
    r = '0;
    idx = (a - rsh_pkg::OFS_OUT_BASE) >> 2;
    if (a == rsh_pkg::OFS_CTRL) begin
      r = {1'b1, 20'h00000, st.ctrl};
    end else if (a == rsh_pkg::OFS_DIV_PRI) begin
      r = {1'b1, 22'h000000, st.div_pri};
    end else if (a == rsh_pkg::OFS_DIV_SEC) begin
      r = {1'b1, 22'h000000, st.div_sec};
    end else if (a == rsh_pkg::OFS_VCO_DIV) begin
      r = {1'b1, 29'h00000000, st.vco_div};
    end else if (a == rsh_pkg::OFS_STATUS) begin
      r[32] = 1'b1;
      r[rsh_pkg::SB_ON_SEC] = (st.sel == rsh_pkg::ST_SECONDARY);
      r[rsh_pkg::SB_HOLD] = (st.sel == rsh_pkg::ST_HOLDOVER);
      r[rsh_pkg::SB_NONREV] = st.nonrev;
      r[rsh_pkg::SB_PRI_OK] = st.sy.pri_s2;
      r[rsh_pkg::SB_SEC_OK] = st.sy.sec_s2;
      r[rsh_pkg::SB_CAL_BUSY] = st.cal_busy;
      r[rsh_pkg::SB_BAND_LSB +: rsh_pkg::BAND_W] = st.band;
    end else if (a >= rsh_pkg::OFS_OUT_BASE && a[1:0] == 2'h0 &&
                 idx < 8'(rsh_pkg::NUM_OUT)) begin
      r = {1'b1, 18'h00000, st.outs[idx[3:0]]};
    end
    return r;
  endfunction

  // Byte-lane merge of write data onto the old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  localparam int CNT_W = rsh_pkg::CNT_W;
  logic [32:0] wr_old;
  logic [31:0] wv;
  logic [32:0] rd_val;
  logic [7:0] widx;
  logic do_write;
  logic pri_ok;
  logic sec_ok;
  logic manual_sec;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    pri_ok = s.sy.pri_s2;
    sec_ok = s.sy.sec_s2;
    wr_old = reg_read(s, s.awaddr);
    wv = merge(wr_old[31:0], s.wdata, s.wstrb);
    widx = (s.awaddr - rsh_pkg::OFS_OUT_BASE) >> 2;
    rd_val = reg_read(s, s_axi_araddr);
    do_write = s.aw_held && s.w_held && !s.bvalid;

    // Input synchronisers
    next_s.sy.pri_s1 = primary_reference_present;
    next_s.sy.pri_s2 = s.sy.pri_s1;
    next_s.sy.sec_s1 = secondary_reference_present;
    next_s.sy.sec_s2 = s.sy.sec_s1;
    next_s.sy.pin_s1 = ref_select_pin;
    next_s.sy.pin_s2 = s.sy.pin_s1;
    next_s.sy.hi_s1 = vco_band_too_high;
    next_s.sy.hi_s2 = s.sy.hi_s1;

    // Write channel capture and response
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (wr_old[32] && s.awaddr != rsh_pkg::OFS_STATUS) ?
                     rsh_pkg::RESP_OKAY : rsh_pkg::RESP_SLVERR;
      if (s.awaddr == rsh_pkg::OFS_CTRL) begin
        next_s.ctrl = wv[rsh_pkg::CTRL_W-1:0];
      end else if (s.awaddr == rsh_pkg::OFS_DIV_PRI &&
                   wv[rsh_pkg::REFDIV_W-1:0] != '0) begin
        next_s.div_pri = wv[rsh_pkg::REFDIV_W-1:0];
      end else if (s.awaddr == rsh_pkg::OFS_DIV_SEC &&
                   wv[rsh_pkg::REFDIV_W-1:0] != '0) begin
        next_s.div_sec = wv[rsh_pkg::REFDIV_W-1:0];
      end else if (s.awaddr == rsh_pkg::OFS_VCO_DIV &&
                   wv[rsh_pkg::VDIV_W-1:0] >= rsh_pkg::VDIV_MIN &&
                   wv[rsh_pkg::VDIV_W-1:0] <= rsh_pkg::VDIV_MAX &&
                   wv[31:rsh_pkg::VDIV_W] == '0) begin
        next_s.vco_div = wv[rsh_pkg::VDIV_W-1:0];
      end else if (wr_old[32] && s.awaddr >= rsh_pkg::OFS_OUT_BASE) begin
        next_s.outs[widx[3:0]] = wv[$bits(rsh_pkg::rsh_out_cfg_t)-1:0];
      end
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val[31:0];
      next_s.rresp = rd_val[32] ? rsh_pkg::RESP_OKAY : rsh_pkg::RESP_SLVERR;
    end

    // Reference selection state machine
    next_s.resync = 1'b0;
    manual_sec = s.ctrl[rsh_pkg::CB_SEL_BY_PIN] ? s.sy.pin_s2 :
                 s.ctrl[rsh_pkg::CB_SEL_SEC];
    if (!pri_ok && !sec_ok && !s.ctrl[rsh_pkg::CB_HOLD_DIS]) begin
      next_s.sel = rsh_pkg::ST_HOLDOVER;
    end else if (s.ctrl[rsh_pkg::CB_MANUAL]) begin
      // No presence check on a manual secondary pick
      next_s.sel = manual_sec ? rsh_pkg::ST_SECONDARY :
                   rsh_pkg::ST_PRIMARY;
      next_s.resync = (s.sel == rsh_pkg::ST_HOLDOVER);
    end else begin
      unique case (s.sel)
        rsh_pkg::ST_PRIMARY: begin
          if (!pri_ok && sec_ok) begin
            next_s.sel = rsh_pkg::ST_SECONDARY;
            if (!s.ctrl[rsh_pkg::CB_REVERTIVE]) begin
              next_s.nonrev = 1'b1;
            end
          end
        end
        rsh_pkg::ST_SECONDARY: begin
          if (!sec_ok) begin
            next_s.sel = rsh_pkg::ST_PRIMARY;
          end else if (pri_ok && s.ctrl[rsh_pkg::CB_REVERTIVE] &&
                       !s.nonrev) begin
            next_s.sel = rsh_pkg::ST_PRIMARY;
          end
        end
        rsh_pkg::ST_HOLDOVER: begin
          if (pri_ok || sec_ok || s.ctrl[rsh_pkg::CB_HOLD_DIS]) begin
            next_s.sel = (pri_ok || !sec_ok) ? rsh_pkg::ST_PRIMARY :
                         rsh_pkg::ST_SECONDARY;
            next_s.resync = 1'b1;
          end
        end
        default: next_s.sel = rsh_pkg::ST_PRIMARY;
      endcase
    end

    // Band calibration by successive approximation
    next_s.cal_prev = s.ctrl[rsh_pkg::CB_CAL];
    if (!s.cal_busy) begin
      if (s.ctrl[rsh_pkg::CB_CAL] && !s.cal_prev) begin
        next_s.cal_busy = 1'b1;
        next_s.cal_idx = 3'(rsh_pkg::BAND_W - 1);
        next_s.band = rsh_pkg::BAND_RST;
        next_s.band[rsh_pkg::BAND_W-1] = 1'b1;
        next_s.cal_cnt = '0;
      end
    end else if (s.cal_cnt != CNT_W'(rsh_pkg::CAL_SETTLE_CYC - 1)) begin
      next_s.cal_cnt = s.cal_cnt + 1'b1;
    end else begin
      next_s.cal_cnt = '0;
      if (s.sy.hi_s2) begin
        next_s.band[s.cal_idx] = 1'b0;
      end
      if (s.cal_idx == 3'h0) begin
        next_s.cal_busy = 1'b0;
      end else begin
        next_s.cal_idx = s.cal_idx - 1'b1;
        next_s.band[s.cal_idx - 1'b1] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      // Presence syncs start as present: no false holdover after reset
      s.sy.pri_s1 <= 1'b1;
      s.sy.pri_s2 <= 1'b1;
      s.sy.sec_s1 <= 1'b1;
      s.sy.sec_s2 <= 1'b1;
      s.sel <= rsh_pkg::ST_PRIMARY;
      s.nonrev <= 1'b0;
      s.ctrl <= rsh_pkg::CTRL_RST;
      s.div_pri <= rsh_pkg::REFDIV_RST;
      s.div_sec <= rsh_pkg::REFDIV_RST;
      s.vco_div <= rsh_pkg::VDIV_MIN;
      s.band <= rsh_pkg::BAND_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus handshakes
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // Holdover only touches the cleanup loop charge pump
  assign use_secondary_reference = (s.sel == rsh_pkg::ST_SECONDARY);
  assign holdover_active = (s.sel == rsh_pkg::ST_HOLDOVER);
  assign cleanup_loop_cp_tristate = holdover_active &&
                                    !s.ctrl[rsh_pkg::CB_HOLD_MID];
  assign cleanup_loop_cp_midsupply = holdover_active &&
                                     s.ctrl[rsh_pkg::CB_HOLD_MID];
  assign cleanup_loop_resync = s.resync;

  // Receiver power-down
  assign diff_receiver_pd = !s.ctrl[rsh_pkg::CB_DIFF_SEL] ||
                            s.ctrl[rsh_pkg::CB_LOOP_PD];
  assign se_buffer_pd_primary = s.ctrl[rsh_pkg::CB_LOOP_PD] ||
                                s.ctrl[rsh_pkg::CB_SE_PD_PRI] ||
                                s.ctrl[rsh_pkg::CB_DIFF_SEL];
  assign se_buffer_pd_secondary = s.ctrl[rsh_pkg::CB_LOOP_PD] ||
                                  s.ctrl[rsh_pkg::CB_SE_PD_SEC] ||
                                  s.ctrl[rsh_pkg::CB_DIFF_SEL];

  // Divider settings
  assign primary_reference_div = s.div_pri;
  assign secondary_reference_div = s.div_sec;
  assign vco_out_div = s.vco_div;
  assign out_cfg = s.outs;
  assign multiplier_loop_doubler_en = s.ctrl[rsh_pkg::CB_DOUBLER];
  assign vco_band = s.band;
  assign vco_cal_busy = s.cal_busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_auto_switch: assert property (
    !s.ctrl[rsh_pkg::CB_MANUAL] && s.sel == rsh_pkg::ST_PRIMARY &&
    !s.sy.pri_s2 && s.sy.sec_s2 |=> use_secondary_reference)
    else $error("auto switch to secondary missed");
  chk_nonrev_stay: assert property (
    !s.ctrl[rsh_pkg::CB_MANUAL] && s.nonrev && s.sy.sec_s2 &&
    s.sel == rsh_pkg::ST_SECONDARY |=> use_secondary_reference)
    else $error("nonrevertive left secondary");
  chk_revert_primary: assert property (
    !s.ctrl[rsh_pkg::CB_MANUAL] && s.ctrl[rsh_pkg::CB_REVERTIVE] &&
    !s.nonrev && s.sy.pri_s2 && s.sel == rsh_pkg::ST_SECONDARY
    |=> s.sel == rsh_pkg::ST_PRIMARY)
    else $error("revertive did not return");
  chk_nonrev_sticky: assert property (
    s.nonrev |=> s.nonrev [*8])
    else $error("switch record cleared");
  chk_holdover_entry: assert property (
    !s.sy.pri_s2 && !s.sy.sec_s2 && !s.ctrl[rsh_pkg::CB_HOLD_DIS]
    |=> holdover_active && (cleanup_loop_cp_tristate ^
                            cleanup_loop_cp_midsupply))
    else $error("holdover not entered");
  chk_holdover_exit: assert property (
    holdover_active && (s.sy.pri_s2 || s.sy.sec_s2)
    |=> !holdover_active && cleanup_loop_resync ##1 !cleanup_loop_resync)
    else $error("holdover exit wrong");
  chk_diff_power: assert property (
    $rose(s.ctrl[rsh_pkg::CB_LOOP_PD]) |-> diff_receiver_pd &&
    se_buffer_pd_primary && se_buffer_pd_secondary)
    else $error("receiver left powered");
  chk_div_range: assert property (
    primary_reference_div != '0 && vco_out_div >= rsh_pkg::VDIV_MIN &&
    vco_out_div <= rsh_pkg::VDIV_MAX)
    else $error("divider out of range");
  chk_write_resp: assert property (
    s.aw_held && s.w_held && !s.bvalid |=> s_axi_bvalid ##0 !s.aw_held)
    else $error("write response missing");
endmodule
`default_nettype wire

/* File: rsh_pkg.sv */
/*
 * Constants, register map and types for the reference switchover and
 * holdover controller.
 * Assumes a 100 MHz register clock and an AXI4-Lite host.
 */
`default_nettype none
package rsh_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CAL_SETTLE_NS = 1000;
  localparam int unsigned CAL_SETTLE_CYC = (CAL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV_PRI = 8'h04;
  localparam logic [7:0] OFS_DIV_SEC = 8'h08;
  localparam logic [7:0] OFS_VCO_DIV = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_OUT_BASE = 8'h40;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 14;
  localparam int CTRL_W = 12;
  localparam int REFDIV_W = 10;
  localparam int OUTDIV_W = 8;
  localparam int DLY_W = 6;
  localparam int BAND_W = 6;
  localparam int VDIV_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [REFDIV_W-1:0] REFDIV_RST = 10'h001;
  localparam logic [VDIV_W-1:0] VDIV_MIN = 3'h3;
  localparam logic [VDIV_W-1:0] VDIV_MAX = 3'h5;
  localparam logic [BAND_W-1:0] BAND_RST = 6'h00;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CB_MANUAL = 0;
  localparam int CB_SEL_BY_PIN = 1;
  localparam int CB_SEL_SEC = 2;
  localparam int CB_REVERTIVE = 3;
  localparam int CB_HOLD_DIS = 4;
  localparam int CB_HOLD_MID = 5;
  localparam int CB_LOOP_PD = 6;
  localparam int CB_DIFF_SEL = 7;
  localparam int CB_SE_PD_PRI = 8;
  localparam int CB_SE_PD_SEC = 9;
  localparam int CB_DOUBLER = 10;
  localparam int CB_CAL = 11;

  // ----------------------------------------------------------------
  // Status bit positions and output register fields
  // ----------------------------------------------------------------
  localparam int SB_ON_SEC = 0;
  localparam int SB_HOLD = 1;
  localparam int SB_NONREV = 2;
  localparam int SB_PRI_OK = 3;
  localparam int SB_SEC_OK = 4;
  localparam int SB_CAL_BUSY = 5;
  localparam int SB_BAND_LSB = 8;
  localparam int OF_DLY_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_PRIMARY, ST_SECONDARY, ST_HOLDOVER} rsh_sel_t;

  typedef struct packed {
    logic [DLY_W-1:0] delay;
    logic [OUTDIV_W-1:0] div_m1;
  } rsh_out_cfg_t;

  typedef struct packed {
    logic pri_s1, pri_s2, sec_s1, sec_s2, pin_s1, pin_s2, hi_s1, hi_s2;
  } rsh_sync_t;

  typedef struct packed {
    rsh_sync_t sy;
    rsh_sel_t sel;
    logic nonrev;
    logic resync;
    logic [CTRL_W-1:0] ctrl;
    logic [REFDIV_W-1:0] div_pri;
    logic [REFDIV_W-1:0] div_sec;
    logic [VDIV_W-1:0] vco_div;
    rsh_out_cfg_t [NUM_OUT-1:0] outs;
    logic aw_held, w_held, bvalid, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cal_busy, cal_prev;
    logic [BAND_W-1:0] band;
    logic [2:0] cal_idx;
    logic [CNT_W-1:0] cal_cnt;
  } rsh_state_t;
endpackage
`default_nettype wire

/* File: rsh_ref_model.sv */
/*
 * Model of the two reference sources and the band comparator.
 * Assumes the bench commands when each source is present.
 */
`timescale 1ns/1ns
`default_nettype none
module rsh_ref_model #(
  parameter logic [5:0] TARGET_BAND = 6'h2b
) (
  // Clock and commands
  input wire logic aclk,
  input wire logic pri_on,
  input wire logic sec_on,
  input wire logic [5:0] vco_band,
  // Monitor and comparator levels
  output logic primary_reference_present,
  output logic secondary_reference_present,
  output logic vco_band_too_high
);
  // Sources appear and vanish only at commanded edges
  always_ff @(posedge aclk) begin
    primary_reference_present <= pri_on;
    secondary_reference_present <= sec_on;
  end
  // Trial band above the band that fits the oscillator
  assign vco_band_too_high = vco_band > TARGET_BAND;
endmodule
`default_nettype wire

/* File: reference_switchover_holdover_tb.sv */
/*
 * Self-checking bench for the switchover controller.
 * Assumes rsh_pkg and the source model rsh_ref_model.
 */
`timescale 1ns/1ns
`default_nettype none
module reference_switchover_holdover_tb;
  localparam logic [5:0] BAND_EXP = 6'h2b;
  logic aclk, aresetn, pri_on, sec_on, pin, pri_p, sec_p, too_high;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, use_sec, hold, cp_tri, cp_mid;
  logic resync, dpd, sepd_p, sepd_s, dbl, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, c;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] div_p, div_s;
  logic [2:0] vdiv;
  logic [5:0] band;
  rsh_pkg::rsh_out_cfg_t [rsh_pkg::NUM_OUT-1:0] ocfg;
  int mismatches, total_checks, resyncs, r0, i;

  rsh_switchover uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .primary_reference_present(pri_p),
    .secondary_reference_present(sec_p), .ref_select_pin(pin),
    .vco_band_too_high(too_high), .use_secondary_reference(use_sec),
    .holdover_active(hold), .cleanup_loop_cp_tristate(cp_tri),
    .cleanup_loop_cp_midsupply(cp_mid), .cleanup_loop_resync(resync),
    .diff_receiver_pd(dpd), .se_buffer_pd_primary(sepd_p),
    .se_buffer_pd_secondary(sepd_s), .primary_reference_div(div_p),
    .secondary_reference_div(div_s), .vco_out_div(vdiv),
    .out_cfg(ocfg), .multiplier_loop_doubler_en(dbl), .vco_band(band),
    .vco_cal_busy(busy)
  );
  rsh_ref_model #(.TARGET_BAND(BAND_EXP)) src_m (
    .aclk(aclk), .pri_on(pri_on), .sec_on(sec_on), .vco_band(band),
    .primary_reference_present(pri_p),
    .secondary_reference_present(sec_p), .vco_band_too_high(too_high)
  );

  // ----------------------------------------------------------------
  // Clock and pulse counter
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (resync === 1'b1) resyncs++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task wrap_up;
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus write, both channels offered together
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, 32'h0);
    if (n == 40) begin
      chk("timeout", 0, 1);
      wrap_up;
    end
  endtask
  // Bus read, response code checked against e
  task rd(input logic [7:0] a, input logic [1:0] e);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, e});
    if (n == 40) begin
      chk("timeout", 0, 1);
      wrap_up;
    end
  endtask
  // Change source presence, then let the synchronisers settle
  task src(input logic p, input logic s);
    @(posedge aclk);
    pri_on <= p; sec_on <= s;
    repeat (7) @(posedge aclk);
    #1;
  endtask
  task rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 0; pri_on = 1; sec_on = 1; pin = 0; wstrb = 4'hf;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; resyncs = 0;
    void'($urandom(79));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    src(1, 1);
    chk("sec", use_sec, 0);
    chk("dpd", dpd, 1);
    rd(8'h10, 2'h0);
    chk("stat", d[4:0], 5'h18);
    rd(8'h3c, 2'h2);
    chk("unmap", d, 0);
    // Nonrevertive automatic switching
    src(0, 1);
    chk("sec", use_sec, 1);
    src(1, 1);
    chk("sec", use_sec, 1);
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h0);
    src(1, 1);
    chk("sec", use_sec, 1);
    rd(8'h10, 2'h0);
    chk("stat", d[2:0], 3'h5);
    src(1, 0);
    chk("sec", use_sec, 0);
    // Holdover entry, mid-supply option, exit
    r0 = resyncs;
    src(0, 0);
    chk("hold", hold, 1);
    chk("tri", cp_tri, 1);
    wr(8'h00, 32'h20);
    src(0, 0);
    chk("mid", {cp_mid, cp_tri}, 2'h2);
    src(0, 1);
    chk("hold", hold, 0);
    chk("sec", use_sec, 1);
    chk("rsync", resyncs, r0 + 1);
    wr(8'h00, 32'h10);
    src(0, 0);
    chk("hold", hold, 0);
    // Reset clears the record; revertive switching
    rst;
    src(1, 1);
    chk("sec", use_sec, 0);
    wr(8'h00, 32'h8);
    src(0, 1);
    chk("sec", use_sec, 1);
    src(1, 1);
    chk("sec", use_sec, 0);
    // Manual by register, then by pin; secondary is present
    wr(8'h00, 32'h5);
    src(1, 1);
    chk("sec", use_sec, 1);
    wr(8'h00, 32'h3);
    for (i = 1; i >= 0; i--) begin
      @(posedge aclk);
      pin <= i[0];
      src(1, 1);
      chk("pin", use_sec, i);
    end
    // Receiver power-down and doubler from random control words
    repeat (8) begin
      c = $urandom & 32'h7c0;
      wr(8'h00, c);
      src(1, 1);
      chk("dpd", dpd, !c[7] | c[6]);
      chk("sep", sepd_p, c[6] | c[8] | c[7]);
      chk("ses", sepd_s, c[6] | c[9] | c[7]);
      chk("dbl", dbl, c[10]);
    end
    // Dividers: limits, zero refused, random values
    wr(8'h04, 32'h3ff);
    wr(8'h04, 32'h0);
    chk("divp", div_p, 10'h3ff);
    c = $urandom_range(1023, 1);
    wr(8'h08, c);
    chk("divs", div_s, c[9:0]);
    for (i = 3; i <= 6; i++) begin
      wr(8'h0c, i);
      chk("vdiv", vdiv, (i > 5) ? 5 : i);
    end
    for (i = 0; i < rsh_pkg::NUM_OUT; i++) begin
      c = $urandom & 32'h3fff;
      wr(8'h40 + 8'(4 * i), c);
      chk("ocfg", ocfg[i], c[13:0]);
    end
    // Band calibration
    wr(8'h00, 32'h800);
    repeat (2) @(posedge aclk);
    chk("busy", busy, 1);
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge aclk);
    chk("busy", busy, 0);
    chk("band", band, BAND_EXP);
    wrap_up;
  end
endmodule
`default_nettype wire
